/* File: test/hmd_priv_mem.sv */
// Byte-wide SRAM and boot ROM model on the private bus
`timescale 1ns/10ps
module hmd_priv_mem
(
  input wire logic clk_i,
  input wire logic [15:0] addr_i,
  input wire logic [7:0] wdata_i,
  input wire logic wdata_oe_i,
  input wire logic oe_n_i,
  input wire logic we_n_i,
  input wire logic rom_cs_n_i,
  output logic [7:0] rdata_o
);
  logic [7:0] mem [0:65535];
  logic [7:0] last;
  logic drive;
  initial
  begin
    for (int i = 0; i < 65536; i++)
    begin
      mem[i] = 8'(i) ^ 8'(i >> 8);
    end
    last = 8'h00;
  end
  ////////////////////////////////////////////////////////////////////////////
  // Whole 16-bit address used, so a missing upper bit aliases
  assign drive = !oe_n_i || !rom_cs_n_i;
  // Released bus flips, never keeps a stale byte
  assign rdata_o = drive ? mem[addr_i] : ~last;
  always @(posedge clk_i)
  begin
    if (drive)
      last <= mem[addr_i];
    if (!we_n_i && wdata_oe_i)
      mem[addr_i] <= wdata_i;
  end
endmodule : hmd_priv_mem

/* File: test/hmd_top_bench.sv */
// Self-checking bench for the host mode, decode and port select block
`timescale 1ns/10ps
module hmd_top_bench;
  import hmd_pkg::*;
  logic ref_clk_i = 1'h0;
  logic nrst_i = 1'h0;
  logic [7:0] s_axi_awaddr = 8'h0, s_axi_araddr = 8'h0;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata;
  logic [3:0] s_axi_wstrb = 4'hf;
  logic s_axi_awvalid = 1'h0, s_axi_wvalid = 1'h0, s_axi_bready = 1'h0;
  logic s_axi_arvalid = 1'h0, s_axi_rready = 1'h0;
  logic s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
  logic [1:0] s_axi_bresp, s_axi_rresp;
  logic shared_mode_strap_i = 1'h1, io_map_strap0_i = 1'h0, io_map_strap1_i = 1'h0;
  logic port_select_pin_i = 1'h0, tp_link_i = 1'h0, aui_link_i = 1'h0;
  logic io_rd_n_i = 1'h1, io_wr_n_i = 1'h1, mem_rd_n_i = 1'h1, mem_wr_n_i = 1'h1;
  logic boot_rom_match_in_n_i = 1'h1, shared_mem_match_in_n_i = 1'h1;
  logic bus_master_grant_i = 1'h0;
  logic [23:0] host_addr_i = 24'h0;
  hmd_mem_req_t host_req_i = '0;
  logic [15:0] host_rdata_o, private_addr_bus_o;
  logic host_ready_o, dev_sel_o, aprom_sel_o, boot_rom_sel_o, host_dma_en_o, shared_mode_o;
  logic [7:0] private_data_i, private_data_o;
  logic private_data_oe_o, boot_rom_chip_select_n_o, sram_oe_n_o, sram_we_n_o;
  logic tp_active_o, aui_active_o;
  int error_cnt = 0;
  int n_compared = 0;
  logic [23:0] io_b, rom_b;
  logic [31:0] rd;
  logic [1:0] rs;
  logic [15:0] w;
  logic [7:0] e;
  int lat1, lat2, lat3;
  // Port table: ctrl, field, pin, tp link, aui link, expected tp
  logic [7:0] ptab [8] = '{8'h11, 8'h08, 8'h2e, 8'h49, 8'h56, 8'h87, 8'h82, 8'h85};

  always #20 ref_clk_i = ~ref_clk_i;

  hmd_top hmd_top_i (.*);

  hmd_priv_mem hmd_priv_mem_i
  (
    .clk_i(ref_clk_i),
    .addr_i(private_addr_bus_o),
    .wdata_i(private_data_o),
    .wdata_oe_i(private_data_oe_o),
    .oe_n_i(sram_oe_n_o),
    .we_n_i(sram_we_n_o),
    .rom_cs_n_i(boot_rom_chip_select_n_o),
    .rdata_o(private_data_i)
  );
  ////////////////////////////////////////////////////////////////////////////
  task automatic chk(input string what, input logic [31:0] seen, input logic [31:0] exp);
    n_compared++;
    if (seen !== exp)
    begin
      error_cnt++;
      $display("BAD %s expected %h seen %h", what, exp, seen);
    end
  endtask : chk

  task automatic cyc(input int n);
    repeat (n) @(posedge ref_clk_i);
  endtask : cyc

  task automatic print_verdict();
    $display("compared %0d mismatches %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask : print_verdict

  task automatic do_reset(input logic shm_n, input logic [1:0] map);
    nrst_i <= 1'h0;
    shared_mode_strap_i <= shm_n;
    io_map_strap1_i <= map[1];
    io_map_strap0_i <= map[0];
    cyc(6);
    nrst_i <= 1'h1;
    cyc(8);
  endtask : do_reset
  ////////////////////////////////////////////////////////////////////////////
  // Handshake judged at the falling edge, acted on at the next rising edge
  task automatic axi_wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
    logic aw_hs, w_hs, b_ok;
    int k;
    b_ok = 1'h0;
    k = 0;
    s_axi_awaddr <= a;
    s_axi_wdata <= d;
    s_axi_awvalid <= 1'h1;
    s_axi_wvalid <= 1'h1;
    s_axi_bready <= 1'h1;
    while (!b_ok && k < 50)
    begin
      @(negedge ref_clk_i);
      aw_hs = s_axi_awvalid && s_axi_awready === 1'h1;
      w_hs = s_axi_wvalid && s_axi_wready === 1'h1;
      b_ok = s_axi_bvalid === 1'h1;
      r = s_axi_bresp;
      @(posedge ref_clk_i);
      if (aw_hs)
        s_axi_awvalid <= 1'h0;
      if (w_hs)
        s_axi_wvalid <= 1'h0;
      if (b_ok)
        s_axi_bready <= 1'h0;
      k++;
    end
    cyc(1);
    if (!b_ok)
      chk("write answer", 32'h0, 32'h1);
  endtask : axi_wr

  task automatic axi_rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
    logic ar_hs, r_ok;
    int k;
    r_ok = 1'h0;
    k = 0;
    s_axi_araddr <= a;
    s_axi_arvalid <= 1'h1;
    s_axi_rready <= 1'h1;
    while (!r_ok && k < 50)
    begin
      @(negedge ref_clk_i);
      ar_hs = s_axi_arvalid && s_axi_arready === 1'h1;
      r_ok = s_axi_rvalid === 1'h1;
      d = s_axi_rdata;
      r = s_axi_rresp;
      @(posedge ref_clk_i);
      if (ar_hs)
        s_axi_arvalid <= 1'h0;
      if (r_ok)
        s_axi_rready <= 1'h0;
      k++;
    end
    cyc(1);
    if (!r_ok)
      chk("read answer", 32'h0, 32'h1);
  endtask : axi_rd

  // Host side of a shared SRAM or boot ROM word transfer
  task automatic shm(input logic rom, input logic wr, input logic [15:0] a,
                     input logic [15:0] wd, output logic [15:0] d, output int lat);
    host_req_i <= '{rd: !wr, wr: wr, addr: a, wdata: wd};
    mem_rd_n_i <= wr;
    mem_wr_n_i <= !wr;
    boot_rom_match_in_n_i <= !rom;
    shared_mem_match_in_n_i <= rom;
    lat = 0;
    @(negedge ref_clk_i);
    while (host_ready_o !== 1'h1 && lat < 40)
    begin
      @(negedge ref_clk_i);
      lat++;
    end
    d = host_rdata_o;
    chk("host ready", 32'(lat < 40), 32'h1);
    @(posedge ref_clk_i);
    host_req_i <= '0;
    mem_rd_n_i <= 1'h1;
    mem_wr_n_i <= 1'h1;
    boot_rom_match_in_n_i <= 1'h1;
    shared_mem_match_in_n_i <= 1'h1;
    cyc(6);
  endtask : shm

  // Decode outputs: x = {dev_sel, aprom_sel, boot_rom_sel}
  task automatic probe(input logic [23:0] a, input logic io, input logic mem,
                       input logic [2:0] x);
    host_addr_i <= a;
    io_rd_n_i <= !io;
    mem_rd_n_i <= !mem;
    cyc(4);
    @(negedge ref_clk_i);
    chk("dev_sel", dev_sel_o, x[2]);
    chk("aprom_sel", aprom_sel_o, x[1]);
    chk("boot_rom_sel", boot_rom_sel_o, x[0]);
    @(posedge ref_clk_i);
  endtask : probe
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    repeat (20000) @(posedge ref_clk_i);
    chk("watchdog", 32'h0, 32'h1);
    print_verdict();
  end

  initial
  begin
    for (int m = 0; m < 4; m++)
    begin
      do_reset(1'h1, 2'(m));
      chk("bus master mode", shared_mode_o, 1'h0);
      io_b = 24'h300 + 24'(m) * 24'h20;
      rom_b = 24'hc8000 + 24'(m) * 24'h4000;
      probe(io_b, 1'h1, 1'h0, 3'h6);
      probe(io_b + 24'hf, 1'h1, 1'h0, 3'h6);
      probe(io_b + 24'h10, 1'h1, 1'h0, 3'h4);
      probe(io_b + 24'h17, 1'h1, 1'h0, 3'h4);
      probe(io_b + 24'h18, 1'h1, 1'h0, 3'h0);
      probe(rom_b, 1'h0, 1'h1, 3'h1);
      probe(rom_b + 24'h3fff, 1'h0, 1'h1, 3'h1);
      probe(rom_b + 24'h4000, 1'h0, 1'h0, 3'h0);
    end
    axi_rd(HMD_REG_CTRL, rd, rs);
    chk("ctrl reset", rd, HMD_CTRL_RESET);
    axi_rd(HMD_REG_MODE, rd, rs);
    chk("mode reset", rd, HMD_MODE_RESET);
    axi_rd(8'h40, rd, rs);
    chk("unmapped rresp", rs, 2'h2);
    chk("unmapped rdata", rd, 32'h0);
    axi_wr(8'h44, 32'h1, rs);
    chk("unmapped bresp", rs, 2'h2);
    axi_wr(HMD_REG_CTRL, 32'hffffffff, rs);
    axi_wr(HMD_REG_MODE, 32'hffffffff, rs);
    bus_master_grant_i <= 1'h1;
    cyc(4);
    chk("mode by strap only", shared_mode_o, 1'h0);
    chk("dma enable", host_dma_en_o, 1'h1);
    for (int i = 0; i < 8; i++)
    begin
      e = ptab[i];
      axi_wr(HMD_REG_CTRL, {30'h0, e[7:6]}, rs);
      axi_wr(HMD_REG_MODE, {23'h0, e[5:4], 7'h0}, rs);
      port_select_pin_i <= e[3];
      tp_link_i <= e[2];
      aui_link_i <= e[1];
      cyc(4);
      @(negedge ref_clk_i);
      chk("tp_active", tp_active_o, e[0]);
      chk("aui_active", aui_active_o, !e[0]);
      @(posedge ref_clk_i);
      axi_rd(HMD_REG_MODE, rd, rs);
      chk("mode readback", rd, {23'h0, e[5:4], 7'h0});
    end
    do_reset(1'h0, 2'h1);
    chk("shared mode", shared_mode_o, 1'h1);
    chk("dma off", host_dma_en_o, 1'h0);
    axi_rd(HMD_REG_STATUS, rd, rs);
    chk("status", rd, 32'h0000_0005);
    probe(24'h320, 1'h1, 1'h0, 3'h6);
    shm(1'h0, 1'h1, 16'h0102, 16'hbeef, w, lat1);
    shm(1'h0, 1'h0, 16'h0102, 16'h0, w, lat1);
    chk("sram word", w, 16'hbeef);
    shm(1'h0, 1'h0, 16'h0104, 16'h0, w, lat2);
    chk("prefetch hit word", w, 16'h0405);
    chk("hit faster", 32'(lat2 < lat1), 32'h1);
    // Differs from the prefetch address only in the upper bits
    shm(1'h0, 1'h0, 16'h8106, 16'h0, w, lat3);
    chk("miss word", w, 16'h8687);
    chk("miss slower", 32'(lat3 > lat2), 32'h1);
    shm(1'h1, 1'h0, 16'h0010, 16'h0, w, lat1);
    chk("boot rom word", w, 16'h1110);
    boot_rom_match_in_n_i <= 1'h0;
    mem_rd_n_i <= 1'h0;
    cyc(4);
    @(negedge ref_clk_i);
    chk("rom chip select on", boot_rom_chip_select_n_o, 1'h0);
    @(posedge ref_clk_i);
    mem_rd_n_i <= 1'h1;
    cyc(4);
    @(negedge ref_clk_i);
    chk("rom chip select off", boot_rom_chip_select_n_o, 1'h1);
    print_verdict();
  end
endmodule : hmd_top_bench

/* File: verilog/hmd_pkg.sv */
// Package: constants and carriers for the host mode, decode and port select block
package hmd_pkg;

  // I/O window
  localparam logic [9:0] HMD_IO_BASE_300 = 10'h300;
  localparam logic [9:0] HMD_IO_STEP = 10'h020;
  localparam int HMD_IO_WINDOW_BYTES = 24;
  localparam int HMD_APROM_BYTES = 16;
  // Boot ROM window
  localparam logic [23:0] HMD_ROM_BASE_300 = 24'h0c8000;
  localparam logic [23:0] HMD_ROM_STEP = 24'h004000;
  localparam int HMD_ROM_WINDOW_BYTES = 16384;

  // Register offsets (byte addresses)
  localparam logic [7:0] HMD_REG_CTRL = 8'h00;
  localparam logic [7:0] HMD_REG_MODE = 8'h04;
  localparam logic [7:0] HMD_REG_STATUS = 8'h08;
  // Field positions
  localparam int HMD_CTRL_PINSEL_BIT = 0;
  localparam int HMD_CTRL_AUTO_BIT = 1;
  localparam int HMD_MODE_PSEL_LO = 7;
  // Reset values
  localparam logic [31:0] HMD_CTRL_RESET = 32'h0000_0000;
  localparam logic [31:0] HMD_MODE_RESET = 32'h0000_0000;

  // Port select codes
  localparam logic [1:0] HMD_PSEL_AUI = 2'h0;
  localparam logic [1:0] HMD_PSEL_TP = 2'h1;

  // Strap sample delay after reset release, cycles
  localparam int HMD_STRAP_WAIT = 2;

  typedef enum logic [2:0]
  {
    HMD_IDLE = 3'b000,
    HMD_LO = 3'b001,
    HMD_HI = 3'b010,
    HMD_WR_LO = 3'b011,
    HMD_WR_HI = 3'b100,
    HMD_DONE = 3'b101
  } hmd_state_t;

  typedef struct packed
  {
    logic rd;
    logic wr;
    logic [15:0] addr;
    logic [15:0] wdata;
  } hmd_mem_req_t;

endpackage : hmd_pkg

/* File: verilog/hmd_port_sel.sv */
// Network port selection: automatic, software or pin
`timescale 1ns/10ps
module hmd_port_sel
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  input wire logic auto_en_i,
  input wire logic pin_sel_en_i,
  input wire logic [1:0] port_select_field_i,
  input wire logic port_select_pin_i,
  input wire logic tp_link_i,
  input wire logic aui_link_i,
  output logic tp_active_o,
  output logic aui_active_o
);
  import hmd_pkg::*;

  logic pin_s1;
  logic pin_s2;
  logic tp_sel;
  logic next_tp_sel;

  always_comb
  begin
    if (pin_sel_en_i)
      next_tp_sel = pin_s2;
    else if (auto_en_i)
      next_tp_sel = tp_link_i || !aui_link_i;
    else
      next_tp_sel = (port_select_field_i == HMD_PSEL_TP);
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      pin_s1 <= 1'b1;
      pin_s2 <= 1'b1;
      tp_sel <= 1'b0;
    end
    else
    begin
      pin_s1 <= port_select_pin_i;
      pin_s2 <= pin_s1;
      tp_sel <= next_tp_sel;
    end
  end

  // One-hot by construction
  assign tp_active_o = tp_sel;
  assign aui_active_o = !tp_sel;

  property p_one_port;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      tp_active_o != aui_active_o;
  endproperty
  a_one_port: assert property (p_one_port) else $error("both or no port active");
  property p_pin_sel;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      $stable(pin_sel_en_i) && pin_sel_en_i && $past(pin_sel_en_i) |-> tp_sel == $past(pin_s2);
  endproperty
  a_pin_sel: assert property (p_pin_sel) else $error("pin select not followed");
endmodule : hmd_port_sel

/* File: verilog/hmd_top.sv */
// Host mode, address decode, byte conversion and port select top
// Operation
// - Bus-master versus shared-memory chosen by strap only, not software.
// - Bus-master boot ROM decoded in memory, window at most 16 KB.
// - Boot ROM base follows I/O base; 300h pairs with C8000h.
// - Bus-master device select from on-chip comparators using I/O map straps.
// - Address ROM, config and controller registers decode a 24-byte window.
// - Bus-master buffers in host memory, touched only while master.
// - Shared-memory structures in device SRAM, also reachable by host.
// - Shared mode: ROM match causes two byte reads, 16-bit word returned.
// - Shared mode: SRAM match causes byte-wide SRAM access for 16-bit host.
// - Full private address compared against prefetch address for hit/miss.
// - Shared mode still decodes registers and address ROM on chip.
// - Exactly one network port active at any time.
// - Automatic selection picks linked port, twisted-pair preferred.
// - Software selection uses two-bit port select field, mode bits 8:7.
// - Pin select enabled: pin high twisted-pair, low AUI.
// - Straps 00,01,10,11 give I/O base 300h,320h,340h,360h.
// - Pin select disabled: pin ignored, automatic selection if enabled, else software selection.
// - Shared strap sampled after reset; low means shared-memory mode.
// - Boot ROM chip select when ROM match and memory read both active.
`timescale 1ns/10ps
module hmd_top
(
  input wire logic ref_clk_i,
  input wire logic nrst_i,
  // AXI4-Lite slave
  input wire logic [7:0] s_axi_awaddr,
  input wire logic s_axi_awvalid,
  output logic s_axi_awready,
  input wire logic [31:0] s_axi_wdata,
  input wire logic [3:0] s_axi_wstrb,
  input wire logic s_axi_wvalid,
  output logic s_axi_wready,
  output logic [1:0] s_axi_bresp,
  output logic s_axi_bvalid,
  input wire logic s_axi_bready,
  input wire logic [7:0] s_axi_araddr,
  input wire logic s_axi_arvalid,
  output logic s_axi_arready,
  output logic [31:0] s_axi_rdata,
  output logic [1:0] s_axi_rresp,
  output logic s_axi_rvalid,
  input wire logic s_axi_rready,
  // Straps and pins
  input wire logic shared_mode_strap_i,
  input wire logic io_map_strap0_i,
  input wire logic io_map_strap1_i,
  input wire logic port_select_pin_i,
  input wire logic tp_link_i,
  input wire logic aui_link_i,
  // Host bus
  input wire logic [23:0] host_addr_i,
  input wire logic io_rd_n_i,
  input wire logic io_wr_n_i,
  input wire logic mem_rd_n_i,
  input wire logic mem_wr_n_i,
  input wire logic boot_rom_match_in_n_i,
  input wire logic shared_mem_match_in_n_i,
  input wire logic bus_master_grant_i,
  input wire hmd_pkg::hmd_mem_req_t host_req_i,
  output logic [15:0] host_rdata_o,
  output logic host_ready_o,
  output logic dev_sel_o,
  output logic aprom_sel_o,
  output logic boot_rom_sel_o,
  output logic host_dma_en_o,
  output logic shared_mode_o,
  // Private bus
  output logic [15:0] private_addr_bus_o,
  input wire logic [7:0] private_data_i,
  output logic [7:0] private_data_o,
  output logic private_data_oe_o,
  output logic boot_rom_chip_select_n_o,
  output logic sram_oe_n_o,
  output logic sram_we_n_o,
  output logic tp_active_o,
  output logic aui_active_o
);
  import hmd_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Input synchronisers, the ten strap, strobe, match and grant pins pass two flops
  localparam int NS = 10;
  logic [NS-1:0] sy1;
  logic [NS-1:0] sy2;
  logic [NS-1:0] pin_raw;
  assign pin_raw = {shared_mode_strap_i, io_map_strap0_i, io_map_strap1_i, io_rd_n_i,
                    io_wr_n_i, mem_rd_n_i, mem_wr_n_i, boot_rom_match_in_n_i,
                    shared_mem_match_in_n_i, bus_master_grant_i};
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      sy1 <= {NS{1'b1}};
      sy2 <= {NS{1'b1}};
    end
    else
    begin
      sy1 <= pin_raw;
      sy2 <= sy1;
    end
  end
  logic s_strap;
  logic s_map0;
  logic s_map1;
  logic s_iord_n;
  logic s_iowr_n;
  logic s_memrd_n;
  logic s_memwr_n;
  logic s_rom_n;
  logic s_shm_n;
  logic s_grant;
  assign {s_strap, s_map0, s_map1, s_iord_n, s_iowr_n, s_memrd_n, s_memwr_n,
          s_rom_n, s_shm_n, s_grant} = sy2;

  ////////////////////////////////////////////////////////////////////////////
  // Strap capture after reset; no software path reaches it
  logic [1:0] wait_cnt;
  logic [1:0] next_wait_cnt;
  logic shared_mode;
  logic next_shared_mode;
  always_comb
  begin
    next_wait_cnt = wait_cnt;
    next_shared_mode = shared_mode;
    // Synchroniser holds its reset value for two edges, so sample only after it
    if (wait_cnt != 2'(HMD_STRAP_WAIT + 1))
    begin
      next_wait_cnt = wait_cnt + 2'h1;
      if (wait_cnt == 2'(HMD_STRAP_WAIT))
        next_shared_mode = !s_strap;
    end
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      wait_cnt <= 2'h0;
      shared_mode <= 1'b0;
    end
    else
    begin
      wait_cnt <= next_wait_cnt;
      shared_mode <= next_shared_mode;
    end
  end
  assign shared_mode_o = shared_mode;

  ////////////////////////////////////////////////////////////////////////////
  // Address decode
  logic [9:0] io_base;
  logic [23:0] rom_base;
  logic [1:0] map_sel;
  logic [9:0] io_off;
  logic [23:0] rom_off;
  assign map_sel = {s_map1, s_map0};
  assign io_base = HMD_IO_BASE_300 + 10'(HMD_IO_STEP * map_sel);
  assign rom_base = HMD_ROM_BASE_300 + 24'(HMD_ROM_STEP * map_sel);
  assign io_off = host_addr_i[9:0] - io_base;
  assign rom_off = host_addr_i - rom_base;
  logic io_hit;
  assign io_hit = (host_addr_i[23:10] == 14'h0) && (host_addr_i[9:0] >= io_base)
                  && (io_off < 10'(HMD_IO_WINDOW_BYTES));
  logic rom_hit_bm;
  assign rom_hit_bm = !shared_mode && (host_addr_i >= rom_base)
                      && (rom_off < 24'(HMD_ROM_WINDOW_BYTES));
  logic rom_hit;
  assign rom_hit = shared_mode ? !s_rom_n : rom_hit_bm;
  assign dev_sel_o = io_hit && (!s_iord_n || !s_iowr_n);
  assign aprom_sel_o = io_hit && !s_iord_n && (io_off < 10'(HMD_APROM_BYTES));
  assign boot_rom_sel_o = rom_hit && !s_memrd_n;
  assign host_dma_en_o = !shared_mode && s_grant;

  ////////////////////////////////////////////////////////////////////////////
  // Registers
  logic [31:0] ctrl_reg;
  logic [31:0] mode_reg;
  logic [31:0] next_ctrl_reg;
  logic [31:0] next_mode_reg;
  logic aw_hold;
  logic w_hold;
  logic [7:0] aw_addr;
  logic [31:0] w_data;
  logic [3:0] w_strb;
  logic bvalid;
  logic [1:0] bresp;
  logic rvalid;
  logic [31:0] rdata;
  logic [1:0] rresp;
  logic do_write;
  logic state_busy;
  assign s_axi_awready = !aw_hold && !bvalid;
  assign s_axi_wready = !w_hold && !bvalid;
  assign s_axi_arready = !rvalid;
  assign do_write = aw_hold && w_hold && !bvalid;
  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] st);
    logic [31:0] r;
    r = old;
    for (int i = 0; i < 4; i++)
      if (st[i])
        r[8*i +: 8] = d[8*i +: 8];
    return r;
  endfunction : merge
  always_comb
  begin
    next_ctrl_reg = ctrl_reg;
    next_mode_reg = mode_reg;
    if (do_write && aw_addr == HMD_REG_CTRL)
      next_ctrl_reg = merge(ctrl_reg, w_data, w_strb) & 32'h0000_0003;
    if (do_write && aw_addr == HMD_REG_MODE)
      next_mode_reg = merge(mode_reg, w_data, w_strb) & 32'h0000_0180;
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      ctrl_reg <= HMD_CTRL_RESET;
      mode_reg <= HMD_MODE_RESET;
      aw_hold <= 1'b0;
      w_hold <= 1'b0;
      aw_addr <= 8'h00;
      w_data <= 32'h0000_0000;
      w_strb <= 4'h0;
      bvalid <= 1'b0;
      bresp <= 2'h0;
      rvalid <= 1'b0;
      rdata <= 32'h0000_0000;
      rresp <= 2'h0;
    end
    else
    begin
      ctrl_reg <= next_ctrl_reg;
      mode_reg <= next_mode_reg;
      if (s_axi_awvalid && s_axi_awready)
      begin
        aw_hold <= 1'b1;
        aw_addr <= s_axi_awaddr;
      end
      if (s_axi_wvalid && s_axi_wready)
      begin
        w_hold <= 1'b1;
        w_data <= s_axi_wdata;
        w_strb <= s_axi_wstrb;
      end
      if (do_write)
      begin
        aw_hold <= 1'b0;
        w_hold <= 1'b0;
        bvalid <= 1'b1;
        bresp <= (aw_addr == HMD_REG_CTRL || aw_addr == HMD_REG_MODE) ? 2'h0 : 2'h2;
      end
      else if (bvalid && s_axi_bready)
        bvalid <= 1'b0;
      if (s_axi_arvalid && s_axi_arready)
      begin
        rvalid <= 1'b1;
        rresp <= 2'h0;
        unique case (s_axi_araddr)
          HMD_REG_CTRL: rdata <= ctrl_reg;
          HMD_REG_MODE: rdata <= mode_reg;
          HMD_REG_STATUS: rdata <= {27'h0, state_busy, map_sel, tp_active_o, shared_mode};
          default:
          begin
            rdata <= 32'h0000_0000;
            rresp <= 2'h2;
          end
        endcase
      end
      else if (rvalid && s_axi_rready)
        rvalid <= 1'b0;
    end
  end
  assign s_axi_bvalid = bvalid;
  assign s_axi_bresp = bresp;
  assign s_axi_rvalid = rvalid;
  assign s_axi_rdata = rdata;
  assign s_axi_rresp = rresp;

  ////////////////////////////////////////////////////////////////////////////
  // Shared-mode byte conversion with prefetch
  hmd_state_t state;
  hmd_state_t next_state;
  logic [15:0] pa;
  logic [15:0] next_pa;
  logic [15:0] rbuf;
  logic [15:0] next_rbuf;
  logic [15:0] pf_addr;
  logic [15:0] next_pf_addr;
  logic pf_valid;
  logic next_pf_valid;
  logic [7:0] pf_byte;
  logic [7:0] next_pf_byte;
  logic is_rom;
  logic next_is_rom;
  logic sram_go;
  logic rom_go;
  logic pf_hit;
  assign state_busy = (state != HMD_IDLE);
  assign sram_go = shared_mode && !s_shm_n && host_req_i.rd != host_req_i.wr;
  assign rom_go = shared_mode && !s_rom_n && !s_memrd_n;
  assign pf_hit = pf_valid && (pf_addr == host_req_i.addr);
  always_comb
  begin
    next_state = state;
    next_pa = pa;
    next_rbuf = rbuf;
    next_pf_addr = pf_addr;
    next_pf_valid = pf_valid;
    next_pf_byte = pf_byte;
    next_is_rom = is_rom;
    unique case (state)
      HMD_IDLE:
        if (rom_go || (sram_go && host_req_i.rd))
        begin
          next_is_rom = rom_go;
          next_pa = host_req_i.addr;
          if (!rom_go && pf_hit)
          begin
            next_rbuf[7:0] = pf_byte;
            next_pa = host_req_i.addr + 16'h1;
            next_state = HMD_HI;
          end
          else
          begin
            next_pf_valid = 1'b0;
            next_state = HMD_LO;
          end
        end
        else if (sram_go)
        begin
          next_pa = host_req_i.addr;
          next_pf_valid = 1'b0;
          next_state = HMD_WR_LO;
        end
      HMD_LO:
      begin
        next_rbuf[7:0] = private_data_i;
        next_pa = pa + 16'h1;
        next_state = HMD_HI;
      end
      HMD_HI:
      begin
        next_rbuf[15:8] = private_data_i;
        if (!is_rom)
        begin
          next_pf_addr = pa + 16'h1;
          next_pf_valid = 1'b1;
          next_pf_byte = 8'h00;
        end
        next_state = HMD_DONE;
      end
      HMD_WR_LO:
      begin
        next_pa = pa + 16'h1;
        next_state = HMD_WR_HI;
      end
      HMD_WR_HI:
        next_state = HMD_DONE;
      HMD_DONE:
        if (s_memrd_n && s_memwr_n)
          next_state = HMD_IDLE;
      default:
        next_state = HMD_IDLE;
    endcase
  end
  always_ff @(posedge ref_clk_i)
  begin
    if (!nrst_i)
    begin
      state <= HMD_IDLE;
      pa <= 16'h0000;
      rbuf <= 16'h0000;
      pf_addr <= 16'h0000;
      pf_valid <= 1'b0;
      pf_byte <= 8'h00;
      is_rom <= 1'b0;
    end
    else
    begin
      state <= next_state;
      pa <= next_pa;
      rbuf <= next_rbuf;
      pf_addr <= next_pf_addr;
      pf_valid <= next_pf_valid;
      pf_byte <= (state == HMD_DONE && pf_valid && !is_rom) ? private_data_i : next_pf_byte;
      is_rom <= next_is_rom;
    end
  end
  assign private_addr_bus_o = (state == HMD_DONE) ? pf_addr : pa;
  assign private_data_o = (state == HMD_WR_LO) ? host_req_i.wdata[7:0]
                                                : host_req_i.wdata[15:8];
  assign private_data_oe_o = (state == HMD_WR_LO) || (state == HMD_WR_HI);
  assign sram_we_n_o = !private_data_oe_o;
  assign sram_oe_n_o = !(!is_rom && (state == HMD_LO || state == HMD_HI || state == HMD_DONE));
  assign boot_rom_chip_select_n_o = !(!s_rom_n && !s_memrd_n);
  assign host_rdata_o = rbuf;
  assign host_ready_o = (state == HMD_DONE);

  ////////////////////////////////////////////////////////////////////////////
  hmd_port_sel u_port_sel
  (
    .ref_clk_i(ref_clk_i),
    .nrst_i(nrst_i),
    .auto_en_i(ctrl_reg[HMD_CTRL_AUTO_BIT]),
    .pin_sel_en_i(ctrl_reg[HMD_CTRL_PINSEL_BIT]),
    .port_select_field_i(mode_reg[HMD_MODE_PSEL_LO +: 2]),
    .port_select_pin_i(port_select_pin_i),
    .tp_link_i(tp_link_i),
    .aui_link_i(aui_link_i),
    .tp_active_o(tp_active_o),
    .aui_active_o(aui_active_o)
  );

  // Synchroniser bits read directly: ROM match is bit 2, memory read bit 4
  property p_rom_cs;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      (!sy2[2] && !sy2[4]) |-> !boot_rom_chip_select_n_o;
  endproperty
  a_rom_cs: assert property (p_rom_cs) else $error("rom cs");
  property p_base300;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      map_sel == 2'h0 |-> io_base == 10'h300 && rom_base == 24'h0c8000;
  endproperty
  a_base300: assert property (p_base300) else $error("base pair");
  property p_strap;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      wait_cnt == 2'h3 && $past(wait_cnt) == 2'h3 |-> $stable(shared_mode);
  endproperty
  a_strap: assert property (p_strap) else $error("mode changed");
  property p_dma;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      host_dma_en_o |-> s_grant && !shared_mode;
  endproperty
  a_dma: assert property (p_dma) else $error("dma without grant");
  property p_two_bytes;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      state == HMD_LO |=> state == HMD_HI ##1 state == HMD_DONE;
  endproperty
  a_two_bytes: assert property (p_two_bytes) else $error("byte pair broken");
  property p_miss;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      state == HMD_IDLE && next_state == HMD_LO |=> !pf_valid;
  endproperty
  a_miss: assert property (p_miss) else $error("miss");
  // Bases sit on 32-byte and 16 KB boundaries, so the windows are plain field matches
  property p_window;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      io_hit |-> host_addr_i[9:5] == io_base[9:5] && host_addr_i[4:0] < 5'h18;
  endproperty
  a_window: assert property (p_window) else $error("io window");
  property p_bm_rom;
    @(posedge ref_clk_i) disable iff (!nrst_i)
      rom_hit_bm |-> host_addr_i[23:14] == rom_base[23:14];
  endproperty
  a_bm_rom: assert property (p_bm_rom) else $error("rom window");
endmodule : hmd_top
